// ---- image_map_pkg.sv ----
`default_nettype none
package image_map_pkg;

	localparam int WORD_W = 16;
	localparam int REF_W  = 16;
	localparam int OUT_AW = 12;
	localparam int TAB_AW = 9;
	localparam int PREQ_N = 5;
	localparam int PRSP_N = 4;
	localparam int STAT_N = 35;

	// block lengths, in registers
	localparam logic [15:0] LEN_OUT  = 16'h1000;
	localparam logic [15:0] LEN_M2P  = 16'h0200;
	localparam logic [15:0] LEN_RSV3 = 16'h0200;
	localparam logic [15:0] LEN_RSV4 = 16'h0009;
	localparam logic [15:0] LEN_PREQ = 16'h0005;
	localparam logic [15:0] LEN_RSV6 = 16'h0072;
	localparam logic [15:0] LEN_RSV7 = 16'h0036;
	localparam logic [15:0] LEN_PRSP = 16'h0004;
	localparam logic [15:0] LEN_RSV9 = 16'h0032;
	localparam logic [15:0] LEN_STAT = 16'h0023;
	localparam logic [15:0] LEN_INP  = 16'h1000;
	localparam logic [15:0] LEN_P2M  = 16'h0200;
	localparam logic [15:0] IMG_LEN  = 16'h270f;

	// block starts follow from the lengths, so they never move
	localparam logic [15:0] REF_FIRST = 16'h9c41;
	localparam logic [15:0] ST_OUT  = REF_FIRST;
	localparam logic [15:0] ST_M2P  = 16'(ST_OUT + LEN_OUT);
	localparam logic [15:0] ST_RSV3 = 16'(ST_M2P + LEN_M2P);
	localparam logic [15:0] ST_RSV4 = 16'(ST_RSV3 + LEN_RSV3);
	localparam logic [15:0] ST_PREQ = 16'(ST_RSV4 + LEN_RSV4);
	localparam logic [15:0] ST_RSV6 = 16'(ST_PREQ + LEN_PREQ);
	localparam logic [15:0] ST_RSV7 = 16'(ST_RSV6 + LEN_RSV6);
	localparam logic [15:0] ST_PRSP = 16'(ST_RSV7 + LEN_RSV7);
	localparam logic [15:0] ST_RSV9 = 16'(ST_PRSP + LEN_PRSP);
	localparam logic [15:0] ST_STAT = 16'(ST_RSV9 + LEN_RSV9);
	localparam logic [15:0] ST_INP  = 16'(ST_STAT + LEN_STAT);
	localparam logic [15:0] ST_P2M  = 16'(ST_INP + LEN_INP);
	localparam logic [15:0] REF_END = 16'(ST_P2M + LEN_P2M);

	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam int DIG_CH_W = 2;
	localparam int ANA_W    = 12;

	typedef enum logic [3:0] {
		BLK_NONE, BLK_OUT, BLK_M2P, BLK_RSV, BLK_PREQ,
		BLK_PRSP, BLK_RSV_RO, BLK_STAT, BLK_INP, BLK_P2M
	} blk_t;

endpackage
`default_nettype wire

// ---- img_port_if.sv ----
`default_nettype none
interface img_port_if #(
	parameter int DEPTH = 4096,
	parameter int NRD   = 2
);
	localparam int AW = $clog2(DEPTH);

	logic                                             we;
	logic [AW-1:0]                                    widx;
	logic [image_map_pkg::WORD_W-1:0]                 wdata;
	logic [NRD-1:0][AW-1:0]                           ridx;
	logic [NRD-1:0][image_map_pkg::WORD_W-1:0]        rdata;

	modport store (input we, widx, wdata, ridx, output rdata);
	modport user  (output we, widx, wdata, ridx, input rdata);
endinterface
`default_nettype wire

// ---- img_store.sv ----
`default_nettype none
module img_store #(
	parameter int DEPTH = 4096,
	parameter int NRD   = 2
) (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// storage port
	img_port_if.store port
);
	typedef struct packed {
		logic [DEPTH-1:0][image_map_pkg::WORD_W-1:0] mem;
	} store_t;

	store_t state_reg;
	store_t state_next;

	always_comb
	begin
		state_next = state_reg;
		if (port.we)
			state_next.mem[port.widx] = port.wdata;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	// reads are combinational so the caller can register them
	always_comb
	begin
		for (int k = 0; k < NRD; k++)
			port.rdata[k] = state_reg.mem[port.ridx[k]];
	end
endmodule
`default_nettype wire

// ---- blk_decode.sv ----
`default_nettype none
module blk_decode (
	// reference number in
	input  wire logic [image_map_pkg::REF_W-1:0] i_ref,
	// block and offset out
	output image_map_pkg::blk_t                  o_blk,
	output logic [image_map_pkg::REF_W-1:0]      o_off
);
	always_comb
	begin
		o_blk = image_map_pkg::BLK_NONE;
		o_off = image_map_pkg::WORD_ZERO;
		if (i_ref < image_map_pkg::REF_FIRST || i_ref >= image_map_pkg::REF_END)
			o_blk = image_map_pkg::BLK_NONE;
		else if (i_ref < image_map_pkg::ST_M2P)
		begin
			o_blk = image_map_pkg::BLK_OUT;
			o_off = 16'(i_ref - image_map_pkg::ST_OUT);
		end
		else if (i_ref < image_map_pkg::ST_RSV3)
		begin
			o_blk = image_map_pkg::BLK_M2P;
			o_off = 16'(i_ref - image_map_pkg::ST_M2P);
		end
		else if (i_ref < image_map_pkg::ST_PREQ)
			o_blk = image_map_pkg::BLK_RSV;
		else if (i_ref < image_map_pkg::ST_RSV6)
		begin
			o_blk = image_map_pkg::BLK_PREQ;
			o_off = 16'(i_ref - image_map_pkg::ST_PREQ);
		end
		else if (i_ref < image_map_pkg::ST_PRSP)
			o_blk = image_map_pkg::BLK_RSV;
		else if (i_ref < image_map_pkg::ST_RSV9)
		begin
			o_blk = image_map_pkg::BLK_PRSP;
			o_off = 16'(i_ref - image_map_pkg::ST_PRSP);
		end
		else if (i_ref < image_map_pkg::ST_STAT)
			o_blk = image_map_pkg::BLK_RSV_RO;
		else if (i_ref < image_map_pkg::ST_INP)
		begin
			o_blk = image_map_pkg::BLK_STAT;
			o_off = 16'(i_ref - image_map_pkg::ST_STAT);
		end
		else if (i_ref < image_map_pkg::ST_P2M)
		begin
			o_blk = image_map_pkg::BLK_INP;
			o_off = 16'(i_ref - image_map_pkg::ST_INP);
		end
		else
		begin
			o_blk = image_map_pkg::BLK_P2M;
			o_off = 16'(i_ref - image_map_pkg::ST_P2M);
		end
	end
endmodule
`default_nettype wire

// ---- island_data_image_map.sv ----
// Notes on behaviour
// R1: image holds 9999 consecutive registers numbered from 40001.
// R2: every register is 16 bits, bit 15 most significant.
// R3: output process image is registers 40001 through 44096.
// R4: then a 512-word master-to-panel table, then 512 reserved words.
// R5: then 9 reserved, 5 parameter request, 114 reserved words.
// R6: then 54 reserved, 4 parameter response, 50 read-only reserved words.
// R7: 35 island status registers sit directly before the input image.
// R8: input image is registers 45392 through 49487.
// R9: panel-to-master table is 49488 to 49999; the panel writes it.
// R10: block sizes are fixed, so block starts never shift.
// R11: the configuration port can read every register of the image.
// R12: configuration port writes output image only in test mode.
// R13: fieldbus master writes control data into the output image.
// R14: output words map to output modules in island order.
// R15: digital output word: bit 0 channel one, bit 1 channel two.
// R16: analog output value may sit in upper 11 or 12 bits.
// R17: digital input: one data word then one status word.
// R18: analog input: four words, separate data and status per channel.
// R19: digital outputs are echoed into the input image.
// R20: analog output: two status-only words in the input image.
// R21: output image is read/write, reads show current contents.
// R22: reserved words read zero; writes to them are ignored.
`default_nettype none
module island_data_image_map #(
	parameter int OUT_DEPTH = 4096,
	parameter int TAB_DEPTH = 512
) (
	// clock and reset
	input  wire logic                     i_clk,
	input  wire logic                     i_rst_n,
	// mode
	input  wire logic                     i_test_mode,
	// fieldbus master port
	input  wire logic                     i_fb_req,
	input  wire logic                     i_fb_we,
	input  wire logic [15:0]              i_fb_ref,
	input  wire logic [15:0]              i_fb_wdata,
	output logic                          o_fb_ack,
	output logic                          o_fb_err,
	output logic [15:0]                   o_fb_rdata,
	// configuration port
	input  wire logic                     i_cfg_req,
	input  wire logic                     i_cfg_we,
	input  wire logic [15:0]              i_cfg_ref,
	input  wire logic [15:0]              i_cfg_wdata,
	output logic                          o_cfg_ack,
	output logic                          o_cfg_err,
	output logic [15:0]                   o_cfg_rdata,
	// island side
	input  wire logic [11:0]              i_isl_ridx,
	output logic [15:0]                   o_isl_rdata,
	output logic [1:0]                    o_isl_dig_ch,
	output logic [11:0]                   o_isl_ana,
	input  wire logic                     i_isl_we,
	input  wire logic                     i_isl_echo,
	input  wire logic [11:0]              i_isl_widx,
	input  wire logic [15:0]              i_isl_wdata,
	// parameter transfer and status
	output logic [4:0][15:0]              o_preq,
	input  wire logic [3:0][15:0]         i_presp,
	input  wire logic [34:0][15:0]        i_stat
);
	localparam int OAW = image_map_pkg::OUT_AW;
	localparam int TAW = image_map_pkg::TAB_AW;

	typedef struct packed {
		logic                    fb_ack;
		logic                    fb_err;
		logic [15:0]             fb_rdata;
		logic                    cfg_ack;
		logic                    cfg_err;
		logic [15:0]             cfg_rdata;
		logic [15:0]             isl_rdata;
		logic [4:0][15:0]        preq;
	} map_t;

	map_t state_reg;
	map_t state_next;

	image_map_pkg::blk_t fb_blk;
	image_map_pkg::blk_t cfg_blk;
	logic [15:0]         fb_off;
	logic [15:0]         cfg_off;

	// output image needs a third read port for the island and echo
	img_port_if #(.DEPTH(OUT_DEPTH), .NRD(3)) out_if ();
	img_port_if #(.DEPTH(TAB_DEPTH), .NRD(2)) m2p_if ();
	img_port_if #(.DEPTH(OUT_DEPTH), .NRD(2)) inp_if ();
	img_port_if #(.DEPTH(TAB_DEPTH), .NRD(2)) p2m_if ();

	img_store #(.DEPTH(OUT_DEPTH), .NRD(3)) u_out (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.port    (out_if.store)
	);
	img_store #(.DEPTH(TAB_DEPTH), .NRD(2)) u_m2p (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.port    (m2p_if.store)
	);
	img_store #(.DEPTH(OUT_DEPTH), .NRD(2)) u_inp (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.port    (inp_if.store)
	);
	img_store #(.DEPTH(TAB_DEPTH), .NRD(2)) u_p2m (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.port    (p2m_if.store)
	);

	blk_decode u_fb_dec (
		.i_ref (i_fb_ref),
		.o_blk (fb_blk),
		.o_off (fb_off)
	);
	blk_decode u_cfg_dec (
		.i_ref (i_cfg_ref),
		.o_blk (cfg_blk),
		.o_off (cfg_off)
	);

	// who may write where; the panel owns the output image only in test
	function automatic logic wr_ok(
		input image_map_pkg::blk_t blk,
		input logic                from_cfg,
		input logic                test
	);
		unique case (blk)
			image_map_pkg::BLK_OUT:  wr_ok = from_cfg ? test : !test; // R12 R13
			image_map_pkg::BLK_M2P:  wr_ok = !from_cfg;
			image_map_pkg::BLK_P2M:  wr_ok = from_cfg; // R9
			image_map_pkg::BLK_PREQ: wr_ok = 1'b1;
			default:                 wr_ok = 1'b0;
		endcase
	endfunction

	// a refused write is flagged; reserved and read-only ones just vanish
	function automatic logic wr_refused(
		input image_map_pkg::blk_t blk,
		input logic                ok
	);
		unique case (blk)
			image_map_pkg::BLK_NONE: wr_refused = 1'b1;
			image_map_pkg::BLK_OUT,
			image_map_pkg::BLK_M2P,
			image_map_pkg::BLK_P2M:  wr_refused = !ok;
			default:                 wr_refused = 1'b0; // R22
		endcase
	endfunction

	function automatic logic [15:0] rd_word(
		input image_map_pkg::blk_t blk,
		input logic [15:0]         off,
		input logic [15:0]         out_w,
		input logic [15:0]         m2p_w,
		input logic [15:0]         inp_w,
		input logic [15:0]         p2m_w,
		input logic [4:0][15:0]    preq,
		input logic [3:0][15:0]    presp,
		input logic [34:0][15:0]   stat
	);
		unique case (blk)
			image_map_pkg::BLK_OUT:  rd_word = out_w; // R21
			image_map_pkg::BLK_M2P:  rd_word = m2p_w;
			image_map_pkg::BLK_INP:  rd_word = inp_w;
			image_map_pkg::BLK_P2M:  rd_word = p2m_w;
			image_map_pkg::BLK_PREQ: rd_word = preq[off[2:0]];
			image_map_pkg::BLK_PRSP: rd_word = presp[off[1:0]]; // R6
			image_map_pkg::BLK_STAT: rd_word = stat[off[5:0]]; // R7
			default:                 rd_word = image_map_pkg::WORD_ZERO; // R22
		endcase
	endfunction

	// unmapped references and refused writes answer with an error
	function automatic logic port_err(
		input logic                req,
		input logic                we,
		input image_map_pkg::blk_t blk,
		input logic                ok
	);
		port_err = req && ((blk == image_map_pkg::BLK_NONE)
			|| (we && wr_refused(blk, ok)));
	endfunction

	// a store is written only by a port that may write that block
	function automatic logic wr_hit(
		input logic                wr,
		input logic                ok,
		input image_map_pkg::blk_t blk,
		input image_map_pkg::blk_t want
	);
		wr_hit = wr && ok && (blk == want);
	endfunction

	logic fb_wr;
	logic cfg_wr;
	logic fb_ok;
	logic cfg_ok;
	logic cfg_clash;

	always_comb
	begin
		fb_wr  = i_fb_req && i_fb_we;
		cfg_wr = i_cfg_req && i_cfg_we;
		fb_ok  = wr_ok(fb_blk, 1'b0, i_test_mode);
		// same block written by both ports at once: fieldbus wins
		cfg_clash = fb_wr && fb_ok && (fb_blk == cfg_blk);
		cfg_ok = wr_ok(cfg_blk, 1'b1, i_test_mode) && !cfg_clash;
	end

	// storage hookup; the offset is the image index, blocks never move
	always_comb
	begin
		out_if.ridx[0] = fb_off[OAW-1:0]; // R3 R10
		out_if.ridx[1] = cfg_off[OAW-1:0]; // R11
		out_if.ridx[2] = i_isl_ridx; // R14
		out_if.we      = 1'b0;
		out_if.widx    = fb_off[OAW-1:0];
		out_if.wdata   = i_fb_wdata;
		if (wr_hit(fb_wr, fb_ok, fb_blk, image_map_pkg::BLK_OUT))
			out_if.we = 1'b1; // R13
		else if (wr_hit(cfg_wr, cfg_ok, cfg_blk, image_map_pkg::BLK_OUT))
		begin
			out_if.we    = 1'b1; // R12
			out_if.widx  = cfg_off[OAW-1:0];
			out_if.wdata = i_cfg_wdata;
		end
	end

	always_comb
	begin
		m2p_if.ridx[0] = fb_off[TAW-1:0]; // R4
		m2p_if.ridx[1] = cfg_off[TAW-1:0];
		m2p_if.we      = wr_hit(fb_wr, fb_ok, fb_blk,
			image_map_pkg::BLK_M2P);
		m2p_if.widx    = fb_off[TAW-1:0];
		m2p_if.wdata   = i_fb_wdata;
	end

	always_comb
	begin
		p2m_if.ridx[0] = fb_off[TAW-1:0];
		p2m_if.ridx[1] = cfg_off[TAW-1:0];
		p2m_if.we      = wr_hit(cfg_wr, cfg_ok, cfg_blk,
			image_map_pkg::BLK_P2M);
		p2m_if.widx    = cfg_off[TAW-1:0]; // R9
		p2m_if.wdata   = i_cfg_wdata;
	end

	// island fills the input image; echo copies an output word in
	always_comb
	begin
		inp_if.ridx[0] = fb_off[OAW-1:0]; // R8
		inp_if.ridx[1] = cfg_off[OAW-1:0];
		inp_if.we      = i_isl_we || i_isl_echo; // R17 R18 R20
		inp_if.widx    = i_isl_widx;
		inp_if.wdata   = i_isl_echo ? out_if.rdata[2] : i_isl_wdata; // R19
	end

	always_comb
	begin
		state_next = state_reg;
		state_next.fb_ack  = i_fb_req;
		state_next.cfg_ack = i_cfg_req;
		state_next.fb_err  = port_err(i_fb_req, i_fb_we, fb_blk, fb_ok); // R1
		state_next.cfg_err = port_err(i_cfg_req, i_cfg_we, cfg_blk,
			cfg_ok); // R12
		if (i_fb_req && !i_fb_we)
			state_next.fb_rdata = rd_word(fb_blk, fb_off, out_if.rdata[0],
				m2p_if.rdata[0], inp_if.rdata[0], p2m_if.rdata[0],
				state_reg.preq, i_presp, i_stat); // R2
		if (i_cfg_req && !i_cfg_we)
			state_next.cfg_rdata = rd_word(cfg_blk, cfg_off, out_if.rdata[1],
				m2p_if.rdata[1], inp_if.rdata[1], p2m_if.rdata[1],
				state_reg.preq, i_presp, i_stat); // R11
		state_next.isl_rdata = out_if.rdata[2]; // R14
		// parameter request words: fieldbus first, panel if no clash
		if (fb_wr && fb_blk == image_map_pkg::BLK_PREQ)
			state_next.preq[fb_off[2:0]] = i_fb_wdata; // R5
		else if (cfg_wr && cfg_blk == image_map_pkg::BLK_PREQ)
			state_next.preq[cfg_off[2:0]] = i_cfg_wdata; // R5
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	always_comb
	begin
		o_fb_ack     = state_reg.fb_ack;
		o_fb_err     = state_reg.fb_err;
		o_fb_rdata   = state_reg.fb_rdata;
		o_cfg_ack    = state_reg.cfg_ack;
		o_cfg_err    = state_reg.cfg_err;
		o_cfg_rdata  = state_reg.cfg_rdata;
		o_isl_rdata  = state_reg.isl_rdata;
		// limitation: channel and analog fields assume the module type
		o_isl_dig_ch = state_reg.isl_rdata[image_map_pkg::DIG_CH_W-1:0]; // R15
		o_isl_ana    = state_reg.isl_rdata[15 -: image_map_pkg::ANA_W]; // R16
		o_preq       = state_reg.preq; // R5
	end
endmodule
`default_nettype wire

// ---- image_map_props.sv ----
`default_nettype none
module image_map_props (
	input wire logic        i_clk,
	input wire logic        i_rst_n,
	input wire logic        i_test_mode,
	input wire logic        i_fb_req,
	input wire logic        i_fb_we,
	input wire logic [15:0] i_fb_ref,
	input wire logic        o_fb_ack,
	input wire logic        o_fb_err,
	input wire logic [15:0] o_fb_rdata,
	input wire logic        i_cfg_req,
	input wire logic        i_cfg_we,
	input wire logic [15:0] i_cfg_ref,
	input wire logic        o_cfg_ack,
	input wire logic        o_cfg_err,
	input wire logic [15:0] o_isl_rdata,
	input wire logic [1:0]  o_isl_dig_ch,
	input wire logic [11:0] o_isl_ana
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	function automatic logic inr(logic [15:0] r, lo, hi);
		return r >= lo && r <= hi;
	endfunction

	a_fb_ack_next: assert property (i_fb_req |=> o_fb_ack)
		else $error("fieldbus request not acknowledged");
	a_fb_quiet_idle: assert property (!i_fb_req |=> !o_fb_ack && !o_fb_err)
		else $error("fieldbus answer without request");
	a_cfg_ack_next: assert property (i_cfg_req |=> o_cfg_ack)
		else $error("panel request not acknowledged");
	a_cfg_read_ok: assert property (i_cfg_req && !i_cfg_we
		&& inr(i_cfg_ref, 16'h9c41, 16'hc34f) |=> !o_cfg_err)
		else $error("panel read of image refused");
	a_ref_range_err: assert property (i_fb_req
		&& !inr(i_fb_ref, 16'h9c41, 16'hc34f) |=> o_fb_err)
		else $error("unmapped reference accepted");
	a_cfg_out_lock: assert property (i_cfg_req && i_cfg_we && !i_test_mode
		&& inr(i_cfg_ref, 16'h9c41, 16'hac40) |=> o_cfg_err)
		else $error("panel output write outside test mode");
	a_fb_out_lock: assert property (i_fb_req && i_fb_we && i_test_mode
		&& inr(i_fb_ref, 16'h9c41, 16'hac40) |=> o_fb_err)
		else $error("fieldbus output write in test mode");
	a_fb_p2m_lock: assert property (i_fb_req && i_fb_we
		&& inr(i_fb_ref, 16'hc150, 16'hc34f) |=> o_fb_err)
		else $error("fieldbus write to panel table");
	a_rsv_reads_zero: assert property (i_fb_req && !i_fb_we
		&& inr(i_fb_ref, 16'hae41, 16'hb049)
		|=> o_fb_rdata == 16'h0000 && !o_fb_err)
		else $error("reserved word not zero");
	a_rdata_holds: assert property (!(i_fb_req && !i_fb_we)
		|=> $stable(o_fb_rdata))
		else $error("read data moved without a read");
	a_dig_ch_bits: assert property (o_isl_dig_ch == o_isl_rdata[1:0])
		else $error("digital channels not bits 1:0");
	a_ana_bits: assert property (o_isl_ana == o_isl_rdata[15:4])
		else $error("analog value not upper bits");
endmodule

bind island_data_image_map image_map_props u_props (.i_clk, .i_rst_n,
	.i_test_mode, .i_fb_req, .i_fb_we, .i_fb_ref, .o_fb_ack, .o_fb_err,
	.o_fb_rdata, .i_cfg_req, .i_cfg_we, .i_cfg_ref, .o_cfg_ack, .o_cfg_err,
	.o_isl_rdata, .o_isl_dig_ch, .o_isl_ana);
`default_nettype wire

// ---- island_far_side.sv ----
`default_nettype none
module island_far_side (
	// parameter response and island status words
	output logic [3:0][15:0]  o_presp,
	output logic [34:0][15:0] o_stat
);
	timeunit 1ns;
	timeprecision 1ns;
	// distinct per-word patterns expose any offset slip
	always_comb
	begin
		for (int k = 0; k < 4; k++)
			o_presp[k] = 16'ha500 + 16'(k);
		for (int k = 0; k < 35; k++)
			o_stat[k] = 16'h3c00 + 16'(k);
	end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic FB = 1'b0, PNL = 1'b1, R = 1'b0, W = 1'b1;
	localparam logic OK = 1'b0, BAD = 1'b1;
	localparam logic [15:0] N = 16'h0000;
	localparam logic [15:0] RSV [6] = '{16'hae41, 16'hb049, 16'hb04f,
		16'hb0f6, 16'hb0fb, 16'hb12c};
	logic              i_clk, i_rst_n, i_test_mode;
	logic              i_fb_req, i_fb_we, o_fb_ack, o_fb_err;
	logic              i_cfg_req, i_cfg_we, o_cfg_ack, o_cfg_err;
	logic              i_isl_we, i_isl_echo;
	logic [15:0]       i_fb_ref, i_fb_wdata, o_fb_rdata, d;
	logic [15:0]       i_cfg_ref, i_cfg_wdata, o_cfg_rdata;
	logic [15:0]       o_isl_rdata, i_isl_wdata;
	logic [11:0]       i_isl_ridx, i_isl_widx, o_isl_ana, idx;
	logic [1:0]        o_isl_dig_ch;
	logic [4:0][15:0]  o_preq;
	logic [3:0][15:0]  i_presp;
	logic [34:0][15:0] i_stat;
	int                err_total, cmp_count;

	island_data_image_map DUT (.i_clk, .i_rst_n, .i_test_mode, .i_fb_req,
		.i_fb_we, .i_fb_ref, .i_fb_wdata, .o_fb_ack, .o_fb_err, .o_fb_rdata,
		.i_cfg_req, .i_cfg_we, .i_cfg_ref, .i_cfg_wdata, .o_cfg_ack,
		.o_cfg_err, .o_cfg_rdata, .i_isl_ridx, .o_isl_rdata, .o_isl_dig_ch,
		.o_isl_ana, .i_isl_we, .i_isl_echo, .i_isl_widx, .i_isl_wdata,
		.o_preq, .i_presp, .i_stat);
	island_far_side FAR (.o_presp(i_presp), .o_stat(i_stat));

	function automatic logic [15:0] stat_word(int k);
		return 16'h3c00 + 16'(k);
	endfunction

	task automatic chk(input string nm, input logic [15:0] e, g);
		cmp_count++;
		if (g !== e)
		begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask

	// one request, answer looked at in the cycle the ack stands
	task automatic op(input logic c, w, input logic [15:0] r, dw, ed,
		input logic ee);
		@(negedge i_clk);
		{i_fb_req, i_fb_we, i_fb_ref, i_fb_wdata} = {!c, w, r, dw};
		{i_cfg_req, i_cfg_we, i_cfg_ref, i_cfg_wdata} = {c, w, r, dw};
		@(negedge i_clk);
		chk("ack", 16'h0001, 16'(c ? o_cfg_ack : o_fb_ack));
		chk("err", 16'(ee), 16'(c ? o_cfg_err : o_fb_err));
		if (!w)
			chk("rdata", ed, c ? o_cfg_rdata : o_fb_rdata);
		i_fb_req = 1'b0;
		i_cfg_req = 1'b0;
	endtask

	// both ports write in the same cycle; neither is expected to fail
	task automatic dual(input logic [15:0] fr, cr, fd, cd);
		@(negedge i_clk);
		{i_fb_req, i_fb_we, i_fb_ref, i_fb_wdata} = {2'b11, fr, fd};
		{i_cfg_req, i_cfg_we, i_cfg_ref, i_cfg_wdata} = {2'b11, cr, cd};
		@(negedge i_clk);
		chk("fb ack", 16'h0001, 16'(o_fb_ack));
		chk("cfg ack", 16'h0001, 16'(o_cfg_ack));
		chk("fb err", N, 16'(o_fb_err));
		chk("cfg err", N, 16'(o_cfg_err));
		{i_fb_req, i_cfg_req} = 2'b00;
	endtask

	task automatic isl(input logic [11:0] ri, input logic [15:0] e);
		@(negedge i_clk);
		i_isl_ridx = ri;
		@(negedge i_clk);
		chk("island word", e, o_isl_rdata);
		chk("digital", 16'(e[1:0]), 16'(o_isl_dig_ch));
		chk("analog", 16'(e[15:4]), 16'(o_isl_ana));
	endtask

	task automatic isl_put(input logic e, input logic [11:0] ri, wi,
		input logic [15:0] dw);
		@(negedge i_clk);
		{i_isl_we, i_isl_echo, i_isl_ridx, i_isl_widx, i_isl_wdata} =
			{!e, e, ri, wi, dw};
		@(negedge i_clk);
		{i_isl_we, i_isl_echo} = 2'b00;
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	// generous: the sequence needs well under a tenth of this
	initial
	begin
		#400000;
		err_total++;
		print_verdict();
	end

	initial
	begin
		{i_rst_n, i_test_mode, i_fb_req, i_fb_we, i_cfg_req, i_cfg_we} = '0;
		{i_fb_ref, i_fb_wdata, i_cfg_ref, i_cfg_wdata, i_isl_wdata} = '0;
		{i_isl_we, i_isl_echo, i_isl_ridx, i_isl_widx} = '0;
		err_total = 0;
		cmp_count = 0;
		void'($urandom(32'h125a_f512));
		repeat (16) @(negedge i_clk);
		chk("reset rdata", N, o_fb_rdata);
		i_rst_n = 1'b1;
		op(FB, W, 16'h9c41, 16'h0001, N, OK);
		isl(12'h000, 16'h0001);
		op(FB, W, 16'hac40, 16'hfff0, N, OK);
		isl(12'hfff, 16'hfff0);
		op(PNL, R, 16'hac40, N, 16'hfff0, OK);
		op(PNL, W, 16'h9c41, 16'h1234, N, BAD);
		op(PNL, R, 16'h9c41, N, 16'h0001, OK);
		i_test_mode = 1'b1;
		op(PNL, W, 16'h9c41, 16'h1234, N, OK);
		op(FB, W, 16'h9c41, 16'h5555, N, BAD);
		op(FB, R, 16'h9c41, N, 16'h1234, OK);
		i_test_mode = 1'b0;
		op(FB, W, 16'hac41, 16'hbeef, N, OK);
		op(PNL, R, 16'hac41, N, 16'hbeef, OK);
		op(PNL, W, 16'hac41, 16'h0bad, N, BAD);
		op(PNL, W, 16'hc150, 16'h7777, N, OK);
		op(FB, R, 16'hc150, N, 16'h7777, OK);
		op(FB, W, 16'hc34f, 16'h0bad, N, BAD);
		foreach (RSV[k])
		begin
			op(FB, W, RSV[k], 16'hffff, N, OK);
			op(PNL, R, RSV[k], N, N, OK);
		end
		for (int k = 0; k < 5; k++)
		begin
			op(FB, W, 16'hb04a + 16'(k), 16'h0100 + 16'(k), N, OK);
			chk("request", 16'h0100 + 16'(k), o_preq[k]);
		end
		dual(16'hb04a, 16'hb04b, 16'h0a0a, 16'h0b0b);
		chk("request", 16'h0a0a, o_preq[0]);
		chk("request", 16'h0101, o_preq[1]);
		op(PNL, W, 16'hb04c, 16'h0c0c, N, OK);
		chk("request", 16'h0c0c, o_preq[2]);
		dual(16'h9c42, 16'hc151, 16'h2222, 16'h3333);
		op(FB, R, 16'hc151, N, 16'h3333, OK);
		op(PNL, R, 16'h9c42, N, 16'h2222, OK);
		for (int k = 0; k < 4; k++)
			op(PNL, R, 16'hb0f7 + 16'(k), N, 16'ha500 + 16'(k), OK);
		op(PNL, W, 16'hb0f7, 16'h0bad, N, OK);
		op(PNL, R, 16'hb0f7, N, 16'ha500, OK);
		op(FB, R, 16'hb12d, N, stat_word(0), OK);
		op(FB, R, 16'hb14f, N, stat_word(34), OK);
		isl_put(1'b0, 12'h000, 12'h000, 16'h00a5);
		op(PNL, R, 16'hb150, N, 16'h00a5, OK);
		isl_put(1'b1, 12'h000, 12'hfff, 16'h0f0f);
		op(FB, R, 16'hc14f, N, 16'h1234, OK);
		op(FB, R, 16'h9c40, N, N, BAD);
		op(PNL, R, 16'hc350, N, N, BAD);
		repeat (24)
		begin
			idx = 12'($urandom_range(0, 4095));
			d = 16'($urandom);
			op(FB, W, 16'h9c41 + 16'(idx), d, N, OK);
			op(PNL, R, 16'h9c41 + 16'(idx), N, d, OK);
			isl(idx, d);
		end
		@(negedge i_clk);
		i_rst_n = 1'b0;
		@(negedge i_clk);
		chk("request", N, o_preq[0]);
		i_rst_n = 1'b1;
		op(PNL, R, 16'h9c41, N, N, OK);
		print_verdict();
	end
endmodule
`default_nettype wire
